// ===== design/twm_pkg.sv
// Constants and types shared by the thermal warning monitor
package twm_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] TWM_IDX_CONFIG    = 16'h4002;
	localparam logic [15:0] TWM_IDX_STATUS    = 16'h400D;
	localparam logic [15:0] TWM_IDX_INT_STAT  = 16'h4011;
	localparam logic [15:0] TWM_IDX_INT_MASK  = 16'h4019;

	// Field positions
	localparam int TWM_LEVEL_LSB    = 0;
	localparam int TWM_LEVEL_MSB    = 1;
	localparam int TWM_MARGIN_BIT   = 3;
	localparam int TWM_STS_BIT      = 15;
	localparam int TWM_EVENT_BIT    = 1;
	localparam int TWM_MASK_BIT     = 1;

	// Values after reset
	localparam logic [1:0]  TWM_LEVEL_RST    = 2'h2;
	localparam logic        TWM_MARGIN_RST   = 1'h1;
	localparam logic        TWM_MASK_RST     = 1'h1;
	localparam logic [31:0] TWM_DATA_RST     = 32'h0000_0000;

	// Comparator bundle layout
	localparam int TWM_CMP_WIDTH     = 3;
	localparam int TWM_CMP_SET       = 0;
	localparam int TWM_CMP_RELEASE   = 1;
	localparam int TWM_CMP_SHUTDOWN  = 2;
	localparam int TWM_SYNC_STAGES   = 2;

	// All state of the top module
	typedef struct packed {
		logic [1:0]  level;
		logic        margin;
		logic        warn_flag;
		logic        warn_event;
		logic        event_mask;
		logic        ack;
		logic [31:0] rdata;
		logic        sys_reset;
	} twm_state_t;

endpackage

// ===== design/twm_sync_if.sv
// Carrier between the comparator synchroniser and the monitor core
`timescale 1ns/1ps
interface twm_sync_if;
	import twm_pkg::*;

	logic [TWM_CMP_WIDTH-1:0] raw;
	logic [TWM_CMP_WIDTH-1:0] synced;

	modport sync_side
	(
		input  raw,
		output synced
	);
	modport core_side
	(
		output raw,
		input  synced
	);
endinterface

// ===== design/twm_sync.sv
// Two-stage synchroniser for the analogue comparator outputs
`timescale 1ns/1ps
module twm_sync
	import twm_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	twm_sync_if.sync_side link
);

	typedef struct packed {
		logic [TWM_CMP_WIDTH-1:0] stage1;
		logic [TWM_CMP_WIDTH-1:0] stage2;
	} twm_sync_state_t;

	twm_sync_state_t state_reg;
	twm_sync_state_t state_next;

	// The first stage feeds only the second one
	always_comb
	begin
		state_next        = state_reg;
		state_next.stage1 = link.raw;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign link.synced = state_reg.stage2;

endmodule

// ===== design/twm_top.sv
// Thermal warning monitor: comparator handling, event flag and Wishbone registers
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module twm_top
	import twm_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        pwr_on_i,
	input  wire logic        pwr_sleep_i,
	input  wire logic        cmp_warn_above_i,
	input  wire logic        cmp_warn_release_i,
	input  wire logic        cmp_shutdown_i,
	output logic      [1:0]  warn_level_select_o,
	output logic             warn_margin_select_o,
	output logic             thermal_int_o,
	output logic             sys_reset_o
);

	twm_state_t state_reg;
	twm_state_t state_next;

	twm_sync_if cmp_link ();

	logic        active;
	logic        above;
	logic        release_ok;
	logic        shutdown;
	logic [15:0] index;
	logic        req;
	logic        wr_take;
	logic        ev_clear;
	logic [15:0] rd_word;

	assign cmp_link.raw[TWM_CMP_SET]      = cmp_warn_above_i;
	assign cmp_link.raw[TWM_CMP_RELEASE]  = cmp_warn_release_i;
	assign cmp_link.raw[TWM_CMP_SHUTDOWN] = cmp_shutdown_i;

	// Comparators are asynchronous to clk_i
	twm_sync u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.link  (cmp_link.sync_side)
	);

	assign above      = cmp_link.synced[TWM_CMP_SET];
	assign release_ok = cmp_link.synced[TWM_CMP_RELEASE];
	// Shutdown comparator has its own fixed trip point; no setting reaches it
	assign shutdown   = cmp_link.synced[TWM_CMP_SHUTDOWN];

	assign active  = pwr_on_i | pwr_sleep_i;
	assign index   = wb_adr_i[17:2];
	assign req     = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign wr_take = req & wb_we_i & state_reg.ack;
	assign ev_clear = wr_take && (index == TWM_IDX_INT_STAT) && wb_sel_i[0] && wb_dat_i[TWM_EVENT_BIT];

	always_comb
	begin
		rd_word = 16'h0000;
		unique case (index)
			TWM_IDX_CONFIG:
			begin
				rd_word[TWM_LEVEL_MSB:TWM_LEVEL_LSB] = state_reg.level;
				rd_word[TWM_MARGIN_BIT]              = state_reg.margin;
			end
			TWM_IDX_STATUS:
			begin
				rd_word[TWM_STS_BIT] = state_reg.warn_flag;
			end
			TWM_IDX_INT_STAT:
			begin
				rd_word[TWM_EVENT_BIT] = state_reg.warn_event;
			end
			TWM_IDX_INT_MASK:
			begin
				rd_word[TWM_MASK_BIT] = state_reg.event_mask;
			end
			default:
			begin
				rd_word = 16'h0000;
			end
		endcase
	end

	always_comb
	begin
		state_next = state_reg;

		// One-cycle ack, dropped in the cycle after it was given
		state_next.ack = req & ~state_reg.ack;
		if (req & ~state_reg.ack)
		begin
			state_next.rdata = {16'h0000, rd_word};
		end

		if (wr_take && (index == TWM_IDX_CONFIG))
		begin
			if (wb_sel_i[0])
			begin
				state_next.level  = wb_dat_i[TWM_LEVEL_MSB:TWM_LEVEL_LSB];
				state_next.margin = wb_dat_i[TWM_MARGIN_BIT];
			end
		end
		if (wr_take && (index == TWM_IDX_INT_MASK) && wb_sel_i[0])
		begin
			state_next.event_mask = wb_dat_i[TWM_MASK_BIT];
		end

		// Warning flag tracks the comparators only while the device is powered
		if (active)
		begin
			if (!state_reg.warn_flag && above)
			begin
				state_next.warn_flag = 1'b1;
			end
			else if (state_reg.warn_flag && release_ok)
			begin
				state_next.warn_flag = 1'b0;
			end
		end

		// Clear first so a change in the same cycle still sets the event
		if (ev_clear)
		begin
			state_next.warn_event = 1'b0;
		end
		if (state_next.warn_flag != state_reg.warn_flag)
		begin
			state_next.warn_event = 1'b1;
		end

		state_next.sys_reset = shutdown & active;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg            <= '0;
			state_reg.level      <= TWM_LEVEL_RST;
			state_reg.margin     <= TWM_MARGIN_RST;
			state_reg.event_mask <= TWM_MASK_RST;
			state_reg.rdata      <= TWM_DATA_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign wb_dat_o             = state_reg.rdata;
	assign wb_ack_o             = state_reg.ack;
	assign warn_level_select_o  = state_reg.level;
	assign warn_margin_select_o = state_reg.margin;
	assign thermal_int_o        = state_reg.warn_event & ~state_reg.event_mask;
	assign sys_reset_o          = state_reg.sys_reset;

endmodule

// ===== test/twm_cmp_model.sv
// Comparator model of the analogue temperature sense
`timescale 1ns/1ps
module twm_cmp_model
(
	input  wire logic [1:0] lvl_i,
	input  wire logic       mrg_i,
	input  wire logic [7:0] t_i,
	output logic            hi_o,
	output logic            rel_o,
	output logic            shut_o
);
	wire [7:0] trip = 8'h5A + 8'h0A * lvl_i;
	assign hi_o = t_i >= trip;
	assign rel_o = t_i < trip - (mrg_i ? 8'h10 : 8'h08);
	assign shut_o = t_i >= 8'h8C; // Fixed, blind to warning settings
endmodule

// ===== test/twm_top_checker.sv
// Port assertions for the thermal warning monitor
`timescale 1ns/1ps
module twm_top_checker
	import twm_pkg::*;
(
	input logic        clk_i,
	input logic        rst_i,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [17:0] wb_adr_i,
	input logic [3:0]  wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic        wb_ack_o,
	input logic        pwr_on_i,
	input logic        pwr_sleep_i,
	input logic        cmp_shutdown_i,
	input logic [1:0]  warn_level_select_o,
	input logic        warn_margin_select_o,
	input logic        thermal_int_o,
	input logic        sys_reset_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_wr(idx); wb_cyc_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[17:2] == idx; endsequence
	sequence s_hot; (cmp_shutdown_i && (pwr_on_i || pwr_sleep_i)) [*3]; endsequence
	property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack held");
	property p_rsp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_rsp: assert property (p_rsp) else $error("no ack");
	property p_lvl; s_wr(TWM_IDX_CONFIG) |=> warn_level_select_o == $past(wb_dat_i[1:0]); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_mrg; s_wr(TWM_IDX_CONFIG) |=> warn_margin_select_o == $past(wb_dat_i[3]); endproperty
	a_mrg: assert property (p_mrg) else $error("margin");
	property p_msk; s_wr(TWM_IDX_INT_MASK) ##0 wb_dat_i[1] |=> !thermal_int_o; endproperty
	a_msk: assert property (p_msk) else $error("mask");
	property p_hot; s_hot |=> sys_reset_o; endproperty
	a_hot: assert property (p_hot) else $error("no reset");
	property p_off; !pwr_on_i && !pwr_sleep_i |=> !sys_reset_o; endproperty
	a_off: assert property (p_off) else $error("reset when off");
	property p_syn; $rose(sys_reset_o) |-> $past(cmp_shutdown_i, 3); endproperty
	a_syn: assert property (p_syn) else $error("early reset");
endmodule
bind twm_top twm_top_checker twm_top_checker_inst (.*);

// ===== test/twm_top_tb.sv
// Self-checking bench for the thermal warning monitor
`timescale 1ns/1ps
module twm_top_tb
	import twm_pkg::*;
;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pwr_on_i, pwr_sleep_i, cmp_warn_above_i;
	logic        cmp_warn_release_i, cmp_shutdown_i, warn_margin_select_o, thermal_int_o, sys_reset_o;
	logic [1:0]  warn_level_select_o;
	logic [3:0]  wb_sel_i;
	logic [7:0]  temp;
	logic [17:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	int          n_mismatch, checks_done;
	twm_top twm_top_inst (.*);
	twm_cmp_model twm_cmp_model_inst (.lvl_i(warn_level_select_o), .mrg_i(warn_margin_select_o), .t_i(temp),
		.hi_o(cmp_warn_above_i), .rel_o(cmp_warn_release_i), .shut_o(cmp_shutdown_i));
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// Reads compare against d; no latency is assumed, the watchdog ends a hang
	// Ack and data are looked at mid-cycle, where they have settled; the request stands through the edge after
	task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
		logic [31:0] rd;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, i, 2'b00, d};
		do
			@(negedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (!w)
			chk(rd, d);
		@(posedge clk_i);
	endtask
	task automatic end_sim;
		$display("%0d checks %0d bad", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_reg;
		bus(1'b0, TWM_IDX_CONFIG, 32'hA);
		bus(1'b0, TWM_IDX_STATUS, 32'h0);
		bus(1'b0, TWM_IDX_INT_MASK, 32'h2);
		bus(1'b0, 16'h4003, 32'h0);
		for (int i = 5; i > 1; i--)
			bus(1'b1, TWM_IDX_CONFIG, i & 3);
		bus(1'b0, TWM_IDX_CONFIG, 32'h2);
		$display("t_reg end");
	endtask
	task automatic t_temp;
		{pwr_on_i, pwr_sleep_i} <= 2'b01;
		bus(1'b1, TWM_IDX_INT_MASK, 32'h0);
		temp <= 8'h73;
		repeat (4) @(posedge clk_i);
		bus(1'b0, TWM_IDX_STATUS, 32'h8000);
		@(negedge clk_i);
		chk(32'(thermal_int_o), 32'h1);
		@(posedge clk_i);
		bus(1'b1, TWM_IDX_INT_STAT, 32'h0);
		bus(1'b0, TWM_IDX_INT_STAT, 32'h2);
		bus(1'b1, TWM_IDX_INT_STAT, 32'h2);
		temp <= 8'h68;
		repeat (4) @(posedge clk_i);
		bus(1'b0, TWM_IDX_INT_STAT, 32'h0);
		temp <= 8'h64;
		repeat (4) @(posedge clk_i);
		bus(1'b0, TWM_IDX_STATUS, 32'h0);
		@(negedge clk_i);
		chk(32'(thermal_int_o), 32'h1);
		@(posedge clk_i);
		bus(1'b1, TWM_IDX_INT_MASK, 32'h2);
		@(negedge clk_i);
		chk(32'(thermal_int_o), 32'h0);
		@(posedge clk_i);
		{pwr_on_i, pwr_sleep_i} <= 2'b10;
		temp <= 8'h96;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk(32'(sys_reset_o), 32'h1);
		@(posedge clk_i);
		pwr_on_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(32'(sys_reset_o), 32'h0);
		@(posedge clk_i);
		$display("t_temp end");
	endtask
	initial
	begin
		#100us;
		n_mismatch++;
		end_sim;
	end
	initial
	begin
		{rst_i, pwr_on_i, wb_sel_i} = 6'h3F;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, pwr_sleep_i} = '0;
		temp = 8'h40;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		t_reg;
		t_temp;
		end_sim;
	end
endmodule
